//--- src/cdr_lock_ctrl.v
// top of the cdr lock detector, lock history, output_mute_input and register slave
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`include "cdr_map.vh"

// Behaviour
// - loss of lock rises and acquisition restarts when error exceeds 1000 ppm.
// - free-running acquisition starts the vco at its minimum.
// - vco steps up coarse then finer; loss of lock drops within 250 ppm.
// - after release the frequency loop stops and the phase loop pulls in.
// - free-running mode locks from the data stream alone.
// - once raised, loss of lock holds until within 250 ppm of valid data.
// - reference mode locks to the divided reference, same windows.
// - sticky history bit sets on any loss of lock and stays set.
// - writing one then zero to history-clear clears it until next loss.
// - indicator mode one puts history on the pin; zero live status.
// - lower harmonic raises loss of lock and restarts acquisition.
// - higher harmonics are left to the frequency error path.
// - lower harmonic found within 2^16 bits over transition density.
// - the harmonic detector is off in lock-to-reference mode.
// - output_mute_input select zero: mute high zeroes clock and data.
// - output_mute_input select one: mute high zeroes data, mute low zeroes clock.
// - reference target is reference * 2^ratio / 2^range.
module cdr_lock_ctrl #(
   parameter HARM_WINDOW = `HARM_WINDOW_BITS
) (
   // clock and reset
   input  wire                      clk_i,
   input  wire                      reset_i,
   // avalon-mm slave
   input  wire [`ADDR_WIDTH-1:0]    avs_address_i,
   input  wire                      avs_read_i,
   input  wire                      avs_write_i,
   input  wire [31:0]               avs_writedata_i,
   input  wire [3:0]                avs_byteenable_i,
   output reg  [31:0]               avs_readdata_o,
   output wire                      avs_waitrequest_o,
   // frequency measurements, same clock
   input  wire [19:0]               data_rate_khz_i,
   input  wire                      data_rate_valid_i,
   input  wire [19:0]               reference_clock_input_khz_i,
   // pins from the analog front end
   input  wire                      output_mute_input_i,
   input  wire                      rec_clock_i,
   input  wire                      rec_data_i,
   // pins to the downstream consumer
   output wire                      loss_of_lock_out_o,
   output reg                       recovered_clock_out_o,
   output reg                       data_out_pos_o,
   output reg                       data_out_neg_o,
   output wire                      output_boost_o,
   // loop state
   output wire [`FREQ_WIDTH-1:0]    vco_khz_o,
   output wire                      fll_active_o
);

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   reg [7:0]   reference_config_reg_r;
   reg [7:0]   lock_indicator_control_reg_r;
   reg [7:0]   output_control_reg_r;
   reg         rd_ack_r;
   reg         history_r;
   reg         pending_r;
   reg         harm_seen_r;
   reg         lol_prev_r;
   reg         ref_en_prev_r;
   reg [31:0]  rd_mux;

   wire        ref_mode;
   wire [3:0]  ratio;
   wire [1:0]  range;
   wire        hist_clear;
   wire        ind_mode;
   wire        output_mute_input_sel;

   assign ref_mode    = reference_config_reg_r[`REF_LOCK_EN_BIT];
   assign ratio       = reference_config_reg_r[`REF_RATIO_MSB:`REF_RATIO_LSB];
   assign range       = reference_config_reg_r[`REF_RANGE_MSB:`REF_RANGE_LSB];
   assign hist_clear  = lock_indicator_control_reg_r[`LIC_HIST_CLEAR_BIT];
   assign ind_mode    = lock_indicator_control_reg_r[`LIC_MODE_BIT];
   assign output_mute_input_sel = output_control_reg_r[`OUT_OUTPUT_MUTE_INPUT_SEL_BIT];
   assign output_boost_o = output_control_reg_r[`OUT_BOOST_BIT];

   // ------------------------------------------------------------
   // pin synchronisers: three stages, last two must agree
   // ------------------------------------------------------------
   reg [2:0]   mute_s_r;
   reg [2:0]   clk_s_r;
   reg [2:0]   dat_s_r;
   reg         mute_r;
   reg         rclk_r;
   reg         rdat_r;
   reg         rclk_prev_r;

   always @(posedge clk_i) begin
      if (reset_i) begin
         mute_s_r    <= 3'h0;
         clk_s_r     <= 3'h0;
         dat_s_r     <= 3'h0;
         mute_r      <= 1'b0;
         rclk_r      <= 1'b0;
         rdat_r      <= 1'b0;
         rclk_prev_r <= 1'b0;
      end else begin
         mute_s_r    <= {mute_s_r[1:0], output_mute_input_i};
         clk_s_r     <= {clk_s_r[1:0], rec_clock_i};
         dat_s_r     <= {dat_s_r[1:0], rec_data_i};
         rclk_prev_r <= rclk_r;
         if (mute_s_r[1] == mute_s_r[2]) begin
            mute_r <= mute_s_r[2];
         end
         if (clk_s_r[1] == clk_s_r[2]) begin
            rclk_r <= clk_s_r[2];
         end
         if (dat_s_r[1] == dat_s_r[2]) begin
            rdat_r <= dat_s_r[2];
         end
      end
   end

   // ------------------------------------------------------------
   // target frequency
   // ------------------------------------------------------------
   // reference mode: data rate = reference * 2^ratio / 2^range
   wire [`FREQ_WIDTH-1:0] ref_scaled;
   wire [`FREQ_WIDTH-1:0] target;
   wire                   target_ok;

   assign ref_scaled = ({8'h00, reference_clock_input_khz_i} >> range) << ratio;
   assign target     = ref_mode ? ref_scaled : {8'h00, data_rate_khz_i};
   assign target_ok  = ref_mode ? (reference_clock_input_khz_i != 20'h00000)
                                : data_rate_valid_i;

   // ------------------------------------------------------------
   // acquisition and lock decision
   // ------------------------------------------------------------
   wire        within_tight;
   wire        beyond_loose;
   wire        tracking;
   wire        harm_pulse;
   wire        ref_rise;
   wire        lol_live;
   wire        restart;

   assign ref_rise = ref_mode & ~ref_en_prev_r;
   // hysteresis: 1000 ppm restarts, only 250 ppm releases
   assign restart  = (tracking & beyond_loose) | harm_pulse | ref_rise;
   assign tracking = ~fll_active_o;
   assign lol_live = fll_active_o;

   freq_acquire u_acq (
      .clk_i          (clk_i),
      .reset_i        (reset_i),
      .restart_i      (restart),
      .target_ok_i    (target_ok),
      .target_i       (target),
      .vco_o          (vco_khz_o),
      .fll_on_o       (fll_active_o),
      .within_tight_o (within_tight),
      .beyond_loose_o (beyond_loose)
   );

   harmonic_detect #(
      .WINDOW_BITS (HARM_WINDOW)
   ) u_harm (
      .clk_i       (clk_i),
      .reset_i     (reset_i),
      .enable_i    (tracking & ~ref_mode),
      .bit_i       (rdat_r),
      .bit_valid_i (rclk_r & ~rclk_prev_r),
      .harmonic_o  (harm_pulse)
   );

   // ------------------------------------------------------------
   // sticky history and indicator pin
   // ------------------------------------------------------------
   wire lol_event;

   assign lol_event = (lol_live & ~lol_prev_r) | restart;

   always @(posedge clk_i) begin
      if (reset_i) begin
         history_r     <= 1'b0;
         pending_r     <= 1'b0;
         harm_seen_r   <= 1'b0;
         lol_prev_r    <= 1'b0;
         ref_en_prev_r <= 1'b0;
      end else begin
         lol_prev_r    <= lol_live;
         ref_en_prev_r <= ref_mode;
         if (harm_pulse) begin
            harm_seen_r <= 1'b1;
         end else if (hist_clear) begin
            harm_seen_r <= 1'b0;
         end
         if (hist_clear) begin
            history_r <= 1'b0;
            pending_r <= pending_r | lol_event;
         end else begin
            history_r <= history_r | lol_event | pending_r;
            pending_r <= 1'b0;
         end
      end
   end

   assign loss_of_lock_out_o = ind_mode ? history_r : lol_live;

   // ------------------------------------------------------------
   // output_mute_input of the recovered outputs
   // ------------------------------------------------------------
   reg mute_clk;
   reg mute_dat;

   always @* begin
      if (output_mute_input_sel) begin
         mute_dat = mute_r;
         mute_clk = ~mute_r;
      end else begin
         mute_dat = mute_r;
         mute_clk = mute_r;
      end
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         recovered_clock_out_o <= 1'b0;
         data_out_pos_o        <= 1'b0;
         data_out_neg_o        <= 1'b1;
      end else begin
         recovered_clock_out_o <= rclk_r & ~mute_clk;
         data_out_pos_o        <= rdat_r & ~mute_dat;
         data_out_neg_o        <= ~(rdat_r & ~mute_dat);
      end
   end

   // ------------------------------------------------------------
   // avalon-mm slave: writes take no wait, reads wait one cycle
   // ------------------------------------------------------------
   assign avs_waitrequest_o = avs_read_i & ~rd_ack_r;

   always @* begin
      rd_mux = 32'h00000000;
      case (avs_address_i)
         `ADDR_REFERENCE_CONFIG: rd_mux = {24'h000000, reference_config_reg_r};
         `ADDR_LOCK_INDICATOR:   rd_mux = {24'h000000, lock_indicator_control_reg_r};
         `ADDR_OUTPUT_CONTROL:   rd_mux = {24'h000000, output_control_reg_r};
         `ADDR_STATUS: begin
            rd_mux[`ST_LIVE_LOCK_LOSS_BIT] = lol_live;
            rd_mux[`ST_FLL_ACTIVE_BIT]     = fll_active_o;
            rd_mux[`ST_HARMONIC_BIT]       = harm_seen_r;
            rd_mux[`ST_HISTORY_BIT]        = history_r;
         end
         default: rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         reference_config_reg_r       <= `REF_CONFIG_RESET;
         lock_indicator_control_reg_r <= `LIC_RESET;
         output_control_reg_r         <= `OUT_CONTROL_RESET;
         rd_ack_r                     <= 1'b0;
         avs_readdata_o               <= 32'h00000000;
      end else begin
         rd_ack_r <= avs_read_i & ~rd_ack_r;
         if (avs_read_i && !rd_ack_r) begin
            avs_readdata_o <= rd_mux;
         end
         if (avs_write_i && avs_byteenable_i[0]) begin
            case (avs_address_i)
               `ADDR_REFERENCE_CONFIG: reference_config_reg_r <= avs_writedata_i[7:0];
               `ADDR_LOCK_INDICATOR: lock_indicator_control_reg_r <= avs_writedata_i[7:0];
               `ADDR_OUTPUT_CONTROL: output_control_reg_r <= avs_writedata_i[7:0];
               default: ;
            endcase
         end
      end
   end

endmodule

//--- include/cdr_map.vh
// register map, fields, resets and timing counts of the cdr lock control
`ifndef CDR_MAP_VH
`define CDR_MAP_VH

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define ADDR_REFERENCE_CONFIG   4'h0
`define ADDR_LOCK_INDICATOR     4'h4
`define ADDR_OUTPUT_CONTROL     4'h8
`define ADDR_STATUS             4'hc
`define ADDR_WIDTH              4

// ------------------------------------------------------------
// reference_config_reg fields
// ------------------------------------------------------------
`define REF_LOCK_EN_BIT         0
`define REF_FINE_RB_BIT         1
`define REF_RATIO_LSB           2
`define REF_RATIO_MSB           5
`define REF_RANGE_LSB           6
`define REF_RANGE_MSB           7
`define REF_CONFIG_RESET        8'h00

// ------------------------------------------------------------
// lock_indicator_control_reg fields
// ------------------------------------------------------------
`define LIC_HIST_CLEAR_BIT      6
`define LIC_MODE_BIT            7
`define LIC_RESET               8'h00

// ------------------------------------------------------------
// output_control_reg fields
// ------------------------------------------------------------
`define OUT_BOOST_BIT           0
`define OUT_OUTPUT_MUTE_INPUT_SEL_BIT     1
`define OUT_CONTROL_RESET       8'h00

// ------------------------------------------------------------
// status register fields
// ------------------------------------------------------------
`define ST_LIVE_LOCK_LOSS_BIT   0
`define ST_FLL_ACTIVE_BIT       1
`define ST_HARMONIC_BIT         2
`define ST_HISTORY_BIT          4

// ------------------------------------------------------------
// frequency words, in khz, and acquisition constants
// ------------------------------------------------------------
`define FREQ_WIDTH              28
`define VCO_MIN_KHZ             28'h0002710
`define VCO_MAX_KHZ             28'h00a4cb8
`define STEP_INIT_KHZ           28'h0040000
`define PPM_LOSS                12'h3e8
`define PPM_WINDOW_DIV          12'hfa0
`define HARM_WINDOW_BITS        65536

`endif

//--- src/freq_acquire.v
// frequency acquisition sequencer with the modelled vco frequency word
`include "cdr_map.vh"

module freq_acquire (
   // clock and reset
   input  wire                      clk_i,
   input  wire                      reset_i,
   // control
   input  wire                      restart_i,
   input  wire                      target_ok_i,
   input  wire [`FREQ_WIDTH-1:0]    target_i,
   // state
   output reg  [`FREQ_WIDTH-1:0]    vco_o,
   output wire                      fll_on_o,
   output wire                      within_tight_o,
   output wire                      beyond_loose_o
);

   // ------------------------------------------------------------
   // states
   // ------------------------------------------------------------
   localparam [1:0] ST_ACQ   = 2'b01;
   localparam [1:0] ST_TRACK = 2'b10;

   reg [1:0]               state_r;
   reg [`FREQ_WIDTH-1:0]   step_r;
   wire [`FREQ_WIDTH-1:0]  diff;
   wire [`FREQ_WIDTH-1:0]  next_up;

   // multiply compare keeps the ppm test free of division
   function exceeds;
      input [`FREQ_WIDTH-1:0] d;
      input [11:0]            scale;
      input [`FREQ_WIDTH-1:0] t;
      reg   [39:0]            prod;
      begin
         prod    = d * scale;
         exceeds = prod > {12'h000, t};
      end
   endfunction

   assign diff           = (vco_o > target_i) ? vco_o - target_i : target_i - vco_o;
   assign next_up        = vco_o + step_r;
   assign within_tight_o = target_ok_i & ~exceeds(diff, `PPM_WINDOW_DIV, target_i);
   assign beyond_loose_o = ~target_ok_i | exceeds(diff, `PPM_LOSS, target_i);
   assign fll_on_o       = state_r[0];

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   always @(posedge clk_i) begin
      if (reset_i || restart_i) begin
         state_r <= ST_ACQ;
         vco_o   <= `VCO_MIN_KHZ;
         step_r  <= `STEP_INIT_KHZ;
      end else begin
         case (state_r)
            ST_ACQ: begin
               if (within_tight_o) begin
                  state_r <= ST_TRACK;
               end else if (next_up <= target_i && next_up <= `VCO_MAX_KHZ) begin
                  vco_o <= next_up;
               end else if (step_r > 28'h0000001) begin
                  step_r <= step_r >> 1;
               end
            end
            ST_TRACK: begin
               // the phase loop pulls in the remainder one khz per cycle
               if (vco_o < target_i) begin
                  vco_o <= vco_o + 28'h0000001;
               end else if (vco_o > target_i) begin
                  vco_o <= vco_o - 28'h0000001;
               end
            end
            default: begin
               state_r <= ST_ACQ;
            end
         endcase
      end
   end

endmodule

//--- src/harmonic_detect.v
// lower harmonic detector watching run lengths of the recovered bit stream
`include "cdr_map.vh"

module harmonic_detect #(
   parameter WINDOW_BITS = `HARM_WINDOW_BITS
) (
   // clock and reset
   input  wire   clk_i,
   input  wire   reset_i,
   // bit stream
   input  wire   enable_i,
   input  wire   bit_i,
   input  wire   bit_valid_i,
   // result
   output reg    harmonic_o
);

   reg [16:0]  count_r;
   reg [1:0]   run_r;
   reg         last_r;
   reg         single_r;
   reg         trans_r;
   wire        edge_seen;

   assign edge_seen = bit_i != last_r;

   // ------------------------------------------------------------
   // window: a lower harmonic never shows a one-bit run
   // ------------------------------------------------------------
   always @(posedge clk_i) begin
      if (reset_i || !enable_i) begin
         count_r    <= 17'h00000;
         run_r      <= 2'h0;
         last_r     <= 1'b0;
         single_r   <= 1'b0;
         trans_r    <= 1'b0;
         harmonic_o <= 1'b0;
      end else begin
         harmonic_o <= 1'b0;
         if (bit_valid_i) begin
            last_r <= bit_i;
            if (edge_seen) begin
               trans_r <= 1'b1;
               if (run_r == 2'h1) begin
                  single_r <= 1'b1;
               end
               run_r <= 2'h1;
            end else if (run_r != 2'h3) begin
               run_r <= run_r + 2'h1;
            end
            if (count_r == WINDOW_BITS[16:0] - 17'h00001) begin
               harmonic_o <= trans_r & ~single_r;
               count_r    <= 17'h00000;
               single_r   <= 1'b0;
               trans_r    <= 1'b0;
            end else begin
               count_r <= count_r + 17'h00001;
            end
         end
      end
   end

endmodule

//--- bench/serial_source.sv
// serial bit source standing in for the analog front end of the receiver
module serial_source (
   // clock
   input  wire logic clk_i,
   // one: two-bit runs, a lower harmonic
   input  wire logic slow_i,
   // recovered pins
   output logic      rec_clock_o,
   output logic      rec_data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // --------
   // bit timing
   // --------
   // pins are synchronised inside the block, so one bit lasts 16 cycles
   logic [3:0] ph_r;
   logic [1:0] bit_r;
   initial begin
      ph_r        = 4'h0;
      bit_r       = 2'h0;
      rec_clock_o = 1'b0;
      rec_data_o  = 1'b0;
   end
   always @(posedge clk_i) begin
      ph_r <= ph_r + 4'h1;
      if (ph_r == 4'hf)
         bit_r <= bit_r + 2'h1;
      rec_clock_o <= ph_r[3];
      rec_data_o  <= slow_i ? bit_r[1] : bit_r[0];
   end
endmodule

//--- bench/cdr_lock_ctrl_assertions.sv
// concurrent checks on the cdr lock control ports
`include "cdr_map.vh"
module cdr_lock_ctrl_assertions (
   // clock and reset
   input logic        clk_i,
   input logic        reset_i,
   // register bus
   input logic [3:0]  avs_address_i,
   input logic        avs_read_i,
   input logic        avs_write_i,
   input logic [31:0] avs_writedata_i,
   input logic [3:0]  avs_byteenable_i,
   input logic [31:0] avs_readdata_o,
   input logic        avs_waitrequest_o,
   // loop and pins
   input logic [19:0] data_rate_khz_i,
   input logic        output_mute_input_i,
   input logic        loss_of_lock_out_o,
   input logic        recovered_clock_out_o,
   input logic        data_out_pos_o,
   input logic [27:0] vco_khz_o,
   input logic        fll_active_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // --------
   // control bit shadow from bus writes
   // --------
   logic mode_r, clr_r, sel_r, ref_r;
   always @(posedge clk_i) begin
      if (reset_i) begin
         {mode_r, clr_r, sel_r, ref_r} <= 4'h0;
      end else if (avs_write_i && avs_byteenable_i[0]) begin
         if (avs_address_i == `ADDR_LOCK_INDICATOR)
            {mode_r, clr_r} <= avs_writedata_i[7:6];
         if (avs_address_i == `ADDR_OUTPUT_CONTROL)
            sel_r <= avs_writedata_i[1];
         if (avs_address_i == `ADDR_REFERENCE_CONFIG)
            ref_r <= avs_writedata_i[0];
      end
   end
   wire [27:0] rate = {8'h0, data_rate_khz_i};
   wire [39:0] dif  = {12'h0, (vco_khz_o > rate) ? vco_khz_o - rate : rate - vco_khz_o};
   wire        done = avs_read_i && !avs_waitrequest_o;
   // --------
   // assertions
   // --------
   a_write_no_wait: assert property (avs_write_i |-> !avs_waitrequest_o)
      else $error("write stalled");
   a_read_one_wait: assert property (avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("read answer late");
   a_unmapped_zero: assert property (done && avs_address_i[1:0] != 2'h0 |-> avs_readdata_o == 0)
      else $error("unmapped read not zero");
   a_upper_zero: assert property (done |-> avs_readdata_o[31:8] == 24'h0)
      else $error("upper read bits set");
   a_restart_low: assert property ($rose(fll_active_o) |-> ##[0:2] vco_khz_o == `VCO_MIN_KHZ)
      else $error("restart not at minimum");
   a_release_tight: assert property ($fell(fll_active_o) && !ref_r |-> dif * 40'd4000 <= {12'h0, rate})
      else $error("release outside window");
   a_loose_restart: assert property (!fll_active_o && !ref_r && dif * 40'd1000 > {12'h0, rate}
      |-> ##[1:3] fll_active_o)
      else $error("large error did not restart");
   a_track_step: assert property (!fll_active_o && !$past(fll_active_o)
      |-> vco_khz_o - $past(vco_khz_o) + 28'h1 <= 28'h2)
      else $error("track step too large");
   a_pin_live: assert property (!mode_r |-> loss_of_lock_out_o == fll_active_o)
      else $error("pin not showing live status");
   a_clear_holds: assert property (mode_r && clr_r && $past(clr_r) |-> !loss_of_lock_out_o)
      else $error("history not held low by clear");
   a_mute_both: assert property ((!sel_r && output_mute_input_i)[*7]
      |-> !recovered_clock_out_o && !data_out_pos_o)
      else $error("mute left outputs active");
   a_mute_data: assert property ((sel_r && output_mute_input_i)[*7] |-> !data_out_pos_o)
      else $error("mute left data active");
   a_mute_clock: assert property ((sel_r && !output_mute_input_i)[*7] |-> !recovered_clock_out_o)
      else $error("clock not muted");
   c_lock: cover property ($fell(fll_active_o));
   c_restart: cover property ($rose(fll_active_o) && !ref_r);
   c_sticky: cover property (mode_r && loss_of_lock_out_o && !fll_active_o);
   c_split: cover property (sel_r && output_mute_input_i);
endmodule
bind cdr_lock_ctrl cdr_lock_ctrl_assertions u_chk (
   .clk_i(clk_i), .reset_i(reset_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
   .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .data_rate_khz_i(data_rate_khz_i),
   .output_mute_input_i(output_mute_input_i), .loss_of_lock_out_o(loss_of_lock_out_o),
   .recovered_clock_out_o(recovered_clock_out_o), .data_out_pos_o(data_out_pos_o),
   .vco_khz_o(vco_khz_o), .fll_active_o(fll_active_o));

//--- bench/cdr_lock_ctrl_tb.sv
// self-checking bench for the cdr lock control
`include "cdr_map.vh"
module cdr_lock_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // --------
   // signals
   // --------
   localparam int HWIN = 64;
   logic        clk, rst, rd, wr, valid, mute, slow, rclk, rdat, loss_of_lock_out, rco, dp, dn, bst, fll, waitreq;
   logic [3:0]  addr;
   logic [31:0] wdata, rdata, q;
   logic [19:0] rate, refk;
   logic [27:0] vco;
   int          fails, n_tests;
   cdr_lock_ctrl #(.HARM_WINDOW(HWIN)) i_dut (
      .clk_i(clk), .reset_i(rst), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdata), .avs_byteenable_i(4'h1), .avs_readdata_o(rdata),
      .avs_waitrequest_o(waitreq), .data_rate_khz_i(rate), .data_rate_valid_i(valid),
      .reference_clock_input_khz_i(refk), .output_mute_input_i(mute), .rec_clock_i(rclk),
      .rec_data_i(rdat), .loss_of_lock_out_o(loss_of_lock_out), .recovered_clock_out_o(rco),
      .data_out_pos_o(dp), .data_out_neg_o(dn), .output_boost_o(bst), .vco_khz_o(vco),
      .fll_active_o(fll));
   serial_source i_src (.clk_i(clk), .slow_i(slow), .rec_clock_o(rclk), .rec_data_o(rdat));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // --------
   // helpers
   // --------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask
   // request held until waitrequest low at an edge
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      int n;
      n = 0;
      addr  <= a;
      wdata <= {24'h0, d};
      wr    <= w;
      rd    <= ~w;
      @(posedge clk);
      while (waitreq !== 1'b0 && n < 50) begin
         @(posedge clk);
         n++;
      end
      if (n == 50) fails++;
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_fll(input logic v, input int lim);
      int n;
      n = 0;
      while (fll !== v && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask
   function automatic logic near(input longint t);
      longint d;
      d = longint'(vco) - t;
      if (d < 0) d = -d;
      return d * 4000 <= t;
   endfunction
   task automatic settle(input int t);
      wait_fll(1'b0, 5000);
      chk1(fll, 1'b0);
      chk1(near(t), 1'b1);
   endtask
   task automatic relock(input logic [19:0] r);
      rate <= r;
      @(posedge clk);
      wait_fll(1'b1, 20);
      chk1(fll, 1'b1);
      settle(int'(r));
   endtask
   task automatic watch(input logic [1:0] e);
      logic [1:0] f;
      f = 2'h0;
      repeat (8) @(posedge clk);
      repeat (40) begin
         @(posedge clk);
         f = f | {rco, dp};
      end
      chk({30'h0, f}, {30'h0, e});
   endtask
   // --------
   // scenarios
   // --------
   task automatic t_reset;
      chk1(loss_of_lock_out, 1'b1);
      chk(vco, `VCO_MIN_KHZ);
      for (int a = 0; a < 12; a++) begin
         bus(1'b0, a[3:0], 8'h00);
         chk(q, 32'h0);
      end
   endtask
   task automatic t_free;
      relock(20'd155520);
      repeat (200) @(posedge clk);
      chk(vco, 28'd155520);
      rate <= 20'd155598;
      repeat (300) @(posedge clk);
      chk1(fll, 1'b0);
      chk(vco, 28'd155598);
      relock(20'd311040);
      bus(1'b0, `ADDR_STATUS, 8'h00);
      chk1(q[4], 1'b1);
   endtask
   task automatic t_history;
      bus(1'b1, `ADDR_LOCK_INDICATOR, 8'h40);
      bus(1'b0, `ADDR_STATUS, 8'h00);
      chk1(q[4], 1'b0);
      bus(1'b1, `ADDR_LOCK_INDICATOR, 8'h00);
      bus(1'b0, `ADDR_STATUS, 8'h00);
      chk1(q[4], 1'b0);
      bus(1'b1, `ADDR_LOCK_INDICATOR, 8'h80);
      chk1(loss_of_lock_out, 1'b0);
      relock(20'd77760);
      chk1(loss_of_lock_out, 1'b1);
      bus(1'b1, `ADDR_LOCK_INDICATOR, 8'hc0);
      relock(20'd155520);
      chk1(loss_of_lock_out, 1'b0);
      bus(1'b1, `ADDR_LOCK_INDICATOR, 8'h80);
      repeat (2) @(posedge clk);
      chk1(loss_of_lock_out, 1'b1);
      bus(1'b1, `ADDR_LOCK_INDICATOR, 8'h00);
      chk1(loss_of_lock_out, 1'b0);
   endtask
   task automatic t_harmonic;
      slow <= 1'b1;
      wait_fll(1'b1, 2 * HWIN * 16 + 40);
      chk1(fll, 1'b1);
      slow <= 1'b0;
      bus(1'b0, `ADDR_STATUS, 8'h00);
      chk1(q[2], 1'b1);
      settle(155520);
   endtask
   task automatic t_reference;
      rate <= 20'd240000;
      for (int r = 0; r < 4; r++) begin
         refk <= 20'(15000 << r);
         bus(1'b1, `ADDR_REFERENCE_CONFIG, 8'h00);
         bus(1'b1, `ADDR_REFERENCE_CONFIG, {r[1:0], 6'h11});
         wait_fll(1'b1, 20);
         chk1(fll, 1'b1);
         settle(240000);
      end
      bus(1'b0, `ADDR_REFERENCE_CONFIG, 8'h00);
      chk(q, 32'hd1);
      slow <= 1'b1;
      wait_fll(1'b1, 2 * HWIN * 16 + 40);
      chk1(fll, 1'b0);
      slow <= 1'b0;
      bus(1'b1, `ADDR_REFERENCE_CONFIG, 8'h00);
   endtask
   task automatic t_output_mute_input;
      mute <= 1'b1;
      watch(2'h0);
      chk1(dn, 1'b1);
      mute <= 1'b0;
      watch(2'h3);
      bus(1'b1, `ADDR_OUTPUT_CONTROL, 8'h03);
      chk1(bst, 1'b1);
      mute <= 1'b1;
      watch(2'h2);
      mute <= 1'b0;
      watch(2'h1);
      bus(1'b1, `ADDR_OUTPUT_CONTROL, 8'h00);
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // --------
   // run
   // --------
   initial begin
      {rd, wr, mute, slow} = 4'h0;
      addr  = 4'h0;
      wdata = 32'h0;
      rate  = 20'd77760;
      refk  = 20'h0;
      valid = 1'b1;
      rst   = 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset;
      t_free;
      t_history;
      t_harmonic;
      t_reference;
      t_output_mute_input;
      stop_test;
   end
   // hang guard
   initial begin
      repeat (80000) @(posedge clk);
      fails++;
      stop_test;
   end
endmodule
